// ==== srd_system_reset.sv ====
// Reset merge, brownout, read protection and debug port select
//
// What this block does
// R1 - Chip reset from pin, watchdog, power-on, brownout
// R2 - Reset starts oscillator and initializes flash controller
// R3 - Release: defaults restored, fetch from address 0
// R4 - Reset status output mirrors internal reset
// R5 - Reset pin acts only when function selected
// R6 - 50 ns low pulse resets and wakes
// R7 - Deep power-down ignores the reset pin
// R8 - Brownout interrupt below interrupt level
// R9 - Brownout interrupt readable as status
// R10 - Two selectable brownout reset levels
// R11 - Pattern sets protection; application programming allowed at every level outside reset
// R12 - Level one: no debug, partial programming, no sector 0
// R13 - Level two: no debug, full erase only
// R14 - Level three: no debug, no system programming
// R15 - Programming pin entry disabled on its own
// R16 - Four breakpoints and two watchpoints
// R17 - Reset low scan, high serial debug
// R18 - Serial debug disabled while in reset
// R19 - Tester erases, waits 250 us, scans; the pin model waits and scans but never erases
// R20 - Boundary scan port gives no debug access
// R21 - Hold reset until all sources deassert
`timescale 1ns/100ps
`default_nettype none

module srd_system_reset
    import srd_pkg::*;
#(
    parameter int INIT_CYCLES = 16
)
(
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_reset_pin_n,
    input wire logic i_reset_func_sel,
    input wire logic i_watchdog_reset,
    input wire logic i_power_on_reset,
    input wire logic i_brownout_detector_reset_lvl0,
    input wire logic i_brownout_detector_reset_lvl1,
    input wire logic i_brownout_reset_level_sel,
    input wire logic i_brownout_detector_irq_level,
    input wire logic [2:0] i_power_mode,
    input wire logic [31:0] i_protect_pattern,
    input wire logic i_programming_request_pin,
    input wire logic i_isp_cmd_valid,
    input wire logic i_isp_cmd_full_erase,
    input wire logic i_isp_cmd_sector0,
    input wire logic i_iap_cmd_valid,
    input wire logic i_debug_req,
    input wire logic i_scan_req,
    output logic o_chip_reset,
    output logic o_reset_status_output,
    output logic o_osc_start,
    output logic o_flash_init,
    output logic o_wake,
    output logic [31:0] o_fetch_addr,
    output logic o_brownout_irq,
    output logic o_brownout_status,
    output logic [1:0] o_protect_level,
    output logic o_isp_cmd_allow,
    output logic o_iap_cmd_allow,
    output logic o_prog_pin_entry,
    output logic o_swd_enable,
    output logic o_swd_grant,
    output logic o_scan_select,
    output logic o_scan_grant,
    output logic [2:0] o_num_breakpoints,
    output logic [1:0] o_num_watchpoints
);

    localparam int PULSE_W = $clog2(SRD_MIN_PULSE_CYC + 1);
    localparam int INIT_W = $clog2(INIT_CYCLES + 1);
    // Least pulse may span one edge fewer than its rounded-up
    // cycle count; the low level must be seen PULSE_LAST + 1 times
    localparam int PULSE_LAST = SRD_MIN_PULSE_CYC - 2;

    logic [2:0] pin_sync;
    logic pin_low;
    logic [PULSE_W-1:0] low_cnt;
    logic pin_reset;
    logic [2:0] bod_irq_sync;
    logic brownout_rst;
    logic any_source;
    logic pin_active;
    srd_state_e state;
    logic [INIT_W-1:0] init_cnt;
    logic int_reset;
    srd_prot_e prot;
    srd_prot_e next_prot;
    logic prog_pin_off;

    // Reset pin synchroniser, three stages
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            pin_sync <= 3'h7;
        else
            pin_sync <= {pin_sync[1:0], i_reset_pin_n};
    end

    // Level counts once second and third stages agree
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            pin_low <= 1'b0;
        else if (pin_sync[1] == pin_sync[2])
            pin_low <= ~pin_sync[2];
    end

    // R5 pin gating by function and mode
    // R7 deep power-down ignores pin
    assign pin_active = i_reset_func_sel &&
        (i_power_mode != SRD_PM_DEEP_POWER_DOWN);

    // R6 minimum pulse qualification
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            low_cnt <= '0;
            pin_reset <= 1'b0;
        end
        else if (pin_low && pin_active)
        begin
            if (low_cnt < PULSE_W'(PULSE_LAST))
                low_cnt <= low_cnt + 1'b1;
            else
                pin_reset <= 1'b1;
        end
        // Held until the pin rises, its function drops or deep power-down is entered
        else
        begin
            low_cnt <= '0;
            pin_reset <= 1'b0;
        end
    end

    // Brownout interrupt level synchroniser
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            bod_irq_sync <= 3'h0;
        else
            bod_irq_sync <= {bod_irq_sync[1:0], i_brownout_detector_irq_level};
    end

    // R8 interrupt request to the interrupt controller
    // R9 same level as polled status
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            o_brownout_irq <= 1'b0;
            o_brownout_status <= 1'b0;
        end
        else if (bod_irq_sync[1] == bod_irq_sync[2])
        begin
            o_brownout_irq <= bod_irq_sync[2];
            o_brownout_status <= bod_irq_sync[2];
        end
    end

    // R10 brownout reset level choice
    assign brownout_rst = i_brownout_reset_level_sel ?
        i_brownout_detector_reset_lvl1 : i_brownout_detector_reset_lvl0;

    // R1 merge of four reset sources
    assign any_source = pin_reset | i_watchdog_reset |
        i_power_on_reset | brownout_rst;

    // Reset sequencer: hold, then init, then run
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            state <= SRD_ST_HOLD;
            init_cnt <= '0;
        end
        else
        begin
            case (state)
                SRD_ST_RUN:
                begin
                    init_cnt <= '0;
                    if (any_source)
                        state <= SRD_ST_HOLD;
                end
                // R21 hold while any source active
                SRD_ST_HOLD:
                begin
                    init_cnt <= '0;
                    if (!any_source)
                        state <= SRD_ST_INIT;
                end
                SRD_ST_INIT:
                begin
                    if (any_source)
                        state <= SRD_ST_HOLD;
                    else if (init_cnt == INIT_W'(INIT_CYCLES - 1))
                        state <= SRD_ST_RUN;
                    else
                        init_cnt <= init_cnt + 1'b1;
                end
                default:
                    state <= SRD_ST_HOLD;
            endcase
        end
    end

    // Internal reset: anything but the run state
    assign int_reset = (state != SRD_ST_RUN);

    // R4 status pin mirrors internal reset
    // R2 oscillator start and flash init
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            o_chip_reset <= 1'b1;
            o_reset_status_output <= 1'b1;
            o_osc_start <= 1'b1;
            o_flash_init <= 1'b1;
        end
        else
        begin
            o_chip_reset <= int_reset;
            o_reset_status_output <= int_reset;
            o_osc_start <= int_reset;
            o_flash_init <= (state == SRD_ST_INIT);
        end
    end

    // R6 wake pulse from pin reset in low power modes
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
            o_wake <= 1'b0;
        else
            o_wake <= pin_reset && (i_power_mode != SRD_PM_ACTIVE);
    end

    // R3 boot fetch address on release
    always_ff @(posedge i_mclk)
    begin
        if (i_srst || int_reset)
            o_fetch_addr <= SRD_BOOT_ADDR;
    end

    // R11 decode protection pattern
    always_comb
    begin
        case (i_protect_pattern)
            SRD_PAT_LEVEL_ONE: next_prot = SRD_PROT_ONE;
            SRD_PAT_LEVEL_TWO: next_prot = SRD_PROT_TWO;
            SRD_PAT_LEVEL_THREE: next_prot = SRD_PROT_THREE;
            default: next_prot = SRD_PROT_NONE;
        endcase
    end

    // Pattern latched during reset, stable in run
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            prot <= SRD_PROT_NONE;
            prog_pin_off <= 1'b0;
        end
        else if (int_reset)
        begin
            prot <= next_prot;
            // R15 pin entry disabled separately
            prog_pin_off <= (i_protect_pattern == SRD_PAT_NO_PROG_PIN);
        end
    end

    // Command filtering per protection level
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            o_protect_level <= 2'h0;
            o_isp_cmd_allow <= 1'b0;
            o_iap_cmd_allow <= 1'b0;
            o_prog_pin_entry <= 1'b0;
        end
        else
        begin
            o_protect_level <= prot;
            // R11 application programming unaffected
            o_iap_cmd_allow <= i_iap_cmd_valid && !int_reset;
            case (prot)
                // R12 no sector 0 updates
                SRD_PROT_ONE:
                    o_isp_cmd_allow <= i_isp_cmd_valid && !i_isp_cmd_sector0;
                // R13 full erase only
                SRD_PROT_TWO:
                    o_isp_cmd_allow <= i_isp_cmd_valid && i_isp_cmd_full_erase;
                // R14 all system programming blocked
                SRD_PROT_THREE:
                    o_isp_cmd_allow <= 1'b0;
                default:
                    o_isp_cmd_allow <= i_isp_cmd_valid;
            endcase
            // R14 R15 programming pin entry gating
            o_prog_pin_entry <= i_programming_request_pin && !prog_pin_off &&
                (prot != SRD_PROT_THREE) && int_reset;
        end
    end

    // R17 pin level selects scan or serial debug
    // R18 serial debug off in reset
    // R12 R13 R14 serial debug blocked when protected
    always_ff @(posedge i_mclk)
    begin
        if (i_srst)
        begin
            o_scan_select <= 1'b0;
            o_swd_enable <= 1'b0;
            o_swd_grant <= 1'b0;
            o_scan_grant <= 1'b0;
        end
        else
        begin
            // Pin level taken from the agreed synchroniser output
            o_scan_select <= pin_low;
            o_swd_enable <= !pin_low && !int_reset &&
                (prot == SRD_PROT_NONE);
            o_swd_grant <= i_debug_req && !pin_low && !int_reset &&
                (prot == SRD_PROT_NONE);
            // R20 scan port carries no debug
            o_scan_grant <= i_scan_req && pin_low;
        end
    end

    // R16 debug resource counts
    always_ff @(posedge i_mclk)
    begin
        o_num_breakpoints <= SRD_NUM_BREAKPOINTS;
        o_num_watchpoints <= SRD_NUM_WATCHPOINTS;
    end

endmodule // srd_system_reset

`default_nettype wire

// ==== srd_pkg.sv ====
// Package: constants for the system reset and debug select block
package srd_pkg;
    // Read protection levels decoded from the stored pattern
    typedef enum logic [1:0] {
        SRD_PROT_NONE,
        SRD_PROT_ONE,
        SRD_PROT_TWO,
        SRD_PROT_THREE
    } srd_prot_e;

    // Flash patterns that select a protection level or disable pin entry (arbitrary values)
    localparam logic [31:0] SRD_PAT_LEVEL_ONE = 32'h1234_5678;
    localparam logic [31:0] SRD_PAT_LEVEL_TWO = 32'h8765_4321;
    localparam logic [31:0] SRD_PAT_LEVEL_THREE = 32'h4321_8765;
    localparam logic [31:0] SRD_PAT_NO_PROG_PIN = 32'h4e69_7370;

    // Clock rate and least reset pulse
    localparam int SRD_CLK_MHZ = 250;
    localparam int SRD_MIN_PULSE_NS = 50;
    // Least time rounds up to whole cycles
    localparam int SRD_MIN_PULSE_CYC =
        (SRD_MIN_PULSE_NS * SRD_CLK_MHZ + 999) / 1000;

    // Boot fetch address after reset release
    localparam logic [31:0] SRD_BOOT_ADDR = 32'h0000_0000;

    // Debug resource counts
    localparam logic [2:0] SRD_NUM_BREAKPOINTS = 3'h4;
    localparam logic [1:0] SRD_NUM_WATCHPOINTS = 2'h2;

    // Power modes
    typedef enum logic [2:0] {
        SRD_PM_ACTIVE,
        SRD_PM_SLEEP,
        SRD_PM_DEEP_SLEEP,
        SRD_PM_POWER_DOWN,
        SRD_PM_DEEP_POWER_DOWN
    } srd_pm_e;

    // Reset sequencing states
    typedef enum logic [1:0] {
        SRD_ST_RUN,
        SRD_ST_HOLD,
        SRD_ST_INIT
    } srd_state_e;
endpackage

// ==== srd_system_reset_properties.sv ====
// Checker of reset merge, protection and debug select
`timescale 1ns/100ps
`default_nettype none
module srd_system_reset_properties
    import srd_pkg::*;
#(
    parameter int INIT_CYCLES = 16
)
(
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_watchdog_reset,
    input wire logic i_power_on_reset,
    input wire logic i_brownout_detector_reset_lvl0,
    input wire logic i_brownout_reset_level_sel,
    input wire logic i_iap_cmd_valid,
    input wire logic [2:0] i_power_mode,
    input wire logic o_chip_reset,
    input wire logic o_reset_status_output,
    input wire logic o_osc_start,
    input wire logic o_wake,
    input wire logic o_iap_cmd_allow,
    input wire logic [1:0] o_protect_level,
    input wire logic o_isp_cmd_allow,
    input wire logic o_swd_enable,
    input wire logic o_swd_grant,
    input wire logic o_scan_grant,
    input wire logic o_brownout_irq
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_srst);

    // Reset sources, status and oscillator
    status_mirror_a: assert property (
        o_reset_status_output == o_chip_reset) else $error("status differs");
    osc_start_a: assert property (
        o_osc_start == o_chip_reset) else $error("oscillator not started");
    watchdog_reset_a: assert property (
        i_watchdog_reset |-> ##[1:3] o_chip_reset) else $error("no wdt reset");
    source_hold_a: assert property (
        i_power_on_reset [*4] |-> o_chip_reset) else $error("reset dropped");
    brownout_reset_a: assert property (
        !i_brownout_reset_level_sel && i_brownout_detector_reset_lvl0
        |-> ##[1:3] o_chip_reset) else $error("no brownout reset");
    // Debug access, protection, deep power-down wake and covers
    swd_in_reset_a: assert property (
        o_chip_reset && $past(o_chip_reset) |-> !o_swd_enable)
        else $error("debug port on in reset");
    protect_swd_a: assert property (
        o_protect_level != 2'h0 && $stable(o_protect_level) |-> !o_swd_grant)
        else $error("debug granted while protected");
    level_three_a: assert property (
        o_protect_level == 2'h3 && $stable(o_protect_level)
        |-> !o_isp_cmd_allow) else $error("programming at level three");
    app_prog_a: assert property (
        i_iap_cmd_valid && !o_chip_reset |=> o_iap_cmd_allow || o_chip_reset)
        else $error("application programming refused");
    deep_down_a: assert property (
        i_power_mode == 3'h4 && $past(i_power_mode) == 3'h4 |-> !o_wake)
        else $error("wake in deep power down");
    wake_c: cover property (o_wake);
    scan_c: cover property (o_scan_grant);
    irq_c: cover property (o_brownout_irq);
endmodule // srd_system_reset_properties

bind srd_system_reset srd_system_reset_properties
    #(.INIT_CYCLES(INIT_CYCLES)) u_props (.*);
`default_nettype wire

// ==== srd_pin_model.sv ====
// External reset driver and boundary scan tester model
`timescale 1ns/100ps
`default_nettype none
module srd_pin_model
#(
    parameter int SETTLE_NS = 250000,
    parameter int CLK_NS = 4
)
(
    input wire logic i_mclk,
    output logic o_reset_pin_n,
    output logic o_scan_req
);
    // Pin held high, no scan at start
    initial
    begin
        o_reset_pin_n = 1'b1;
        o_scan_req = 1'b0;
    end
    // Low pulse of n clock cycles
    task automatic pulse(input int n);
        @(posedge i_mclk);
        o_reset_pin_n <= 1'b0;
        repeat (n) @(posedge i_mclk);
        o_reset_pin_n <= 1'b1;
    endtask
    // pin high, settle, pin low, then scan
    task automatic scan_start();
        @(posedge i_mclk);
        o_reset_pin_n <= 1'b1;
        repeat (SETTLE_NS / CLK_NS) @(posedge i_mclk);
        o_reset_pin_n <= 1'b0;
        repeat (8) @(posedge i_mclk);
        o_scan_req <= 1'b1;
    endtask
    task automatic scan_end();
        @(posedge i_mclk);
        o_scan_req <= 1'b0;
        o_reset_pin_n <= 1'b1;
    endtask
endmodule // srd_pin_model
`default_nettype wire

// ==== srd_system_reset_bench.sv ====
// Self-checking bench of the system reset block
`timescale 1ns/100ps
`default_nettype none
module srd_system_reset_bench;
    import srd_pkg::*;
    logic i_mclk = 1'b0, i_srst = 1'b1, i_reset_func_sel = 1'b1;
    logic i_watchdog_reset = 1'b0, i_power_on_reset = 1'b0;
    logic i_brownout_detector_reset_lvl0 = 1'b0;
    logic i_brownout_detector_reset_lvl1 = 1'b0;
    logic i_brownout_reset_level_sel = 1'b0;
    logic i_brownout_detector_irq_level = 1'b0;
    logic [2:0] i_power_mode = 3'h0;
    logic [31:0] i_protect_pattern = 32'h0;
    logic i_programming_request_pin = 1'b1, i_isp_cmd_valid = 1'b0;
    logic i_isp_cmd_full_erase = 1'b0, i_isp_cmd_sector0 = 1'b0;
    logic i_iap_cmd_valid = 1'b0, i_debug_req = 1'b0;
    wire logic i_reset_pin_n, i_scan_req;
    logic o_chip_reset, o_reset_status_output, o_osc_start, o_flash_init;
    logic o_wake, o_brownout_irq, o_brownout_status, o_isp_cmd_allow;
    logic o_iap_cmd_allow, o_prog_pin_entry, o_swd_enable, o_swd_grant;
    logic o_scan_select, o_scan_grant, s_rst, s_wake, s_fi;
    logic [31:0] o_fetch_addr;
    logic [1:0] o_protect_level, o_num_watchpoints;
    logic [2:0] o_num_breakpoints;
    int n_errors = 0, n_tests = 0;
    // Protection rows: pattern, command, expected grants
    typedef struct {
        logic [31:0] pat;
        logic erase, sec0;
        logic [1:0] lvl;
        logic in_system_programming, swd, pin;
    } srd_row_s;
    srd_row_s rows [7] = '{
        '{32'h0, 1'b0, 1'b1, 2'h0, 1'b1, 1'b1, 1'b1},
        '{SRD_PAT_LEVEL_ONE, 1'b0, 1'b0, 2'h1, 1'b1, 1'b0, 1'b1},
        '{SRD_PAT_LEVEL_ONE, 1'b0, 1'b1, 2'h1, 1'b0, 1'b0, 1'b1},
        '{SRD_PAT_LEVEL_TWO, 1'b0, 1'b0, 2'h2, 1'b0, 1'b0, 1'b1},
        '{SRD_PAT_LEVEL_TWO, 1'b1, 1'b0, 2'h2, 1'b1, 1'b0, 1'b1},
        '{SRD_PAT_LEVEL_THREE, 1'b1, 1'b0, 2'h3, 1'b0, 1'b0, 1'b0},
        '{SRD_PAT_NO_PROG_PIN, 1'b0, 1'b0, 2'h0, 1'b1, 1'b1, 1'b0}
    };

    srd_system_reset #(.INIT_CYCLES(2)) DUT (.*);
    srd_pin_model pins (.i_mclk(i_mclk), .o_reset_pin_n(i_reset_pin_n),
        .o_scan_req(i_scan_req));

    // Clock of 4 ns
    always #2 i_mclk = ~i_mclk;

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // Settled samples at falling edges, flags gathered
    task watch(input int n);
        s_rst = 1'b0;
        s_wake = 1'b0;
        repeat (n)
        begin
            @(negedge i_mclk);
            s_rst |= o_chip_reset;
            s_wake |= o_wake;
        end
    endtask
    // Bounded wait for reset release
    task rel();
        int n;
        n = 0;
        s_fi = 1'b0;
        while (o_chip_reset !== 1'b0 && n < 300)
        begin
            @(negedge i_mclk);
            s_fi |= o_flash_init;
            n++;
        end
        if (n == 300)
        begin
            n_errors++;
            finish_test();
        end
    endtask
    task finish_test();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Watchdog on a hang
    initial
    begin
        #400000;
        n_errors++;
        finish_test();
    end
    // Main sequence
    initial
    begin
        watch(1);
        chk("rst", o_chip_reset, 1'b1);
        @(posedge i_mclk);
        i_srst <= 1'b0;
        rel();
        chk("init", s_fi, 1'b1);
        chk("fetch", o_fetch_addr, SRD_BOOT_ADDR);
        chk("bkpt", o_num_breakpoints, 3'h4);
        chk("wpt", o_num_watchpoints, 2'h2);
        foreach (rows[k])
        begin
            @(posedge i_mclk);
            i_protect_pattern <= rows[k].pat;
            i_watchdog_reset <= 1'b1;
            watch(6);
            chk("pin_entry", o_prog_pin_entry, rows[k].pin);
            @(posedge i_mclk);
            i_watchdog_reset <= 1'b0;
            rel();
            @(posedge i_mclk);
            {i_isp_cmd_valid, i_iap_cmd_valid, i_debug_req} <= 3'h7;
            i_isp_cmd_full_erase <= rows[k].erase;
            i_isp_cmd_sector0 <= rows[k].sec0;
            watch(3);
            chk("level", o_protect_level, rows[k].lvl);
            chk("isp", o_isp_cmd_allow, rows[k].in_system_programming);
            chk("swd", o_swd_grant, rows[k].swd);
            chk("iap", o_iap_cmd_allow, 1'b1);
            @(posedge i_mclk);
            {i_isp_cmd_valid, i_iap_cmd_valid} <= 2'h0;
        end
        // Power-on held: reset stays while source is active
        @(posedge i_mclk);
        i_power_on_reset <= 1'b1;
        i_protect_pattern <= 32'h0;
        i_programming_request_pin <= 1'b0;
        watch(10);
        chk("por", o_chip_reset, 1'b1);
        chk("pin_idle", o_prog_pin_entry, 1'b0);
        @(posedge i_mclk);
        i_power_on_reset <= 1'b0;
        rel();
        // Brownout interrupt, then level select
        @(posedge i_mclk);
        i_brownout_detector_irq_level <= 1'b1;
        watch(6);
        chk("irq", o_brownout_irq, 1'b1);
        chk("bo_stat", o_brownout_status, 1'b1);
        @(posedge i_mclk);
        i_brownout_detector_irq_level <= 1'b0;
        i_brownout_reset_level_sel <= 1'b1;
        i_brownout_detector_reset_lvl0 <= 1'b1;
        watch(6);
        chk("irq_off", o_brownout_irq, 1'b0);
        chk("bo_other", s_rst, 1'b0);
        @(posedge i_mclk);
        i_brownout_detector_reset_lvl1 <= 1'b1;
        watch(4);
        chk("bo_rst", o_chip_reset, 1'b1);
        @(posedge i_mclk);
        i_brownout_detector_reset_lvl0 <= 1'b0;
        i_brownout_detector_reset_lvl1 <= 1'b0;
        rel();
        // Level zero chosen: its detector alone resets
        @(posedge i_mclk);
        i_brownout_reset_level_sel <= 1'b0;
        i_brownout_detector_reset_lvl0 <= 1'b1;
        watch(4);
        chk("bo_lvl0", o_chip_reset, 1'b1);
        @(posedge i_mclk);
        i_brownout_detector_reset_lvl0 <= 1'b0;
        rel();
        // Pin pulses of 52 ns: unselected, deep power down, sleep
        @(posedge i_mclk);
        i_reset_func_sel <= 1'b0;
        pins.pulse(13);
        watch(12);
        chk("no_func", s_rst, 1'b0);
        @(posedge i_mclk);
        i_reset_func_sel <= 1'b1;
        i_power_mode <= 3'h4;
        pins.pulse(13);
        watch(12);
        chk("dpd", s_rst | s_wake, 1'b0);
        @(posedge i_mclk);
        i_power_mode <= 3'h1;
        pins.pulse(13);
        watch(12);
        chk("pin_rst", s_rst, 1'b1);
        chk("wake", s_wake, 1'b1);
        @(posedge i_mclk);
        i_power_mode <= 3'h0;
        rel();
        // Boundary scan with pin low, debug still requested
        pins.scan_start();
        watch(3);
        chk("scan_sel", o_scan_select, 1'b1);
        chk("scan", o_scan_grant, 1'b1);
        chk("jtag_dbg", o_swd_grant, 1'b0);
        pins.scan_end();
        watch(6);
        rel();
        watch(2);
        chk("swd_sel", o_scan_select, 1'b0);
        chk("swd_on", o_swd_enable, 1'b1);
        finish_test();
    end
endmodule // srd_system_reset_bench
`default_nettype wire
